/* common/irq_cause_pkg.sv */
package irq_cause_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_FLAG   = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PORT   = 8'h0C;
    localparam logic [7:0] OFS_CONFIG = 8'h10;

    // interrupt flag and mask bit positions
    localparam int BIT_TICK = 0;
    localparam int BIT_PCHG = 1;
    localparam int BIT_EXT  = 2;

    // reset and wake cause bit positions in the status register
    localparam int BIT_PD       = 3;
    localparam int BIT_WDT      = 4;
    localparam int BIT_PIN_WAKE = 7;

    // config register: port direction in low bits, external pin function above
    localparam int BIT_EXT_FN = 8;

    localparam int PORT_W = 8;

    // fetch addresses handed to the core
    localparam logic [9:0] VEC_IRQ  = 10'h008;
    localparam logic [9:0] VEC_TRAP = 10'h001;

    // reset values
    localparam logic [2:0]        FLAG_RST = 3'h0;
    localparam logic [2:0]        MASK_RST = 3'h0;
    localparam logic [PORT_W-1:0] DIR_RST  = 8'hFF;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10
    } run_st_e;

    // one-cycle strobes from the core's instruction decoder
    typedef struct packed {
        logic watchdog_clear_instr;
        logic sleep_instr;
        logic global_irq_on_instr;
        logic global_irq_off_instr;
        logic return_from_isr_instr;
        logic trap_instr;
    } instr_s;

    // vector request towards the core's fetch unit
    typedef struct packed {
        logic       valid;
        logic [9:0] addr;
    } vector_s;

    typedef struct packed {
        run_st_e           st;
        logic              gie;
        logic [2:0]        irq_flag_reg;
        logic [2:0]        irq_mask_reg;
        logic              pin_wake;
        logic              wdt_flag;
        logic              pd_flag;
        logic [PORT_W-1:0] ref_val;
        logic [PORT_W-1:0] dir;
        logic              ext_fn;
        logic              ext_q;
        logic              rpin_q;
        logic              core_rst;
        vector_s           vec;
        logic              wake_cont;
        logic [31:0]       rdata;
    } state_s;

    localparam state_s STATE_RST = '{
        st:           ST_RUN,
        gie:          1'b0,
        irq_flag_reg: FLAG_RST,
        irq_mask_reg: MASK_RST,
        pin_wake:     1'b0,
        wdt_flag:     1'b1,
        pd_flag:      1'b1,
        ref_val:      8'h00,
        dir:          DIR_RST,
        ext_fn:       1'b0,
        ext_q:        1'b1,
        rpin_q:       1'b1,
        core_rst:     1'b0,
        vec:          '{valid: 1'b0, addr: 10'h000},
        wake_cont:    1'b0,
        rdata:        32'h0000_0000
    };

endpackage

/* rtl/irq_and_reset_cause_flags.sv */
// Contract
// - reset on power-up, completed reset-pin low pulse, or watchdog expiry.
// - power-on reset: pin-wake 0, watchdog flag 1, power-down flag 1.
// - pin reset while running: pin-wake 0, other two flags kept.
// - pin reset waking from sleep: pin-wake 0, watchdog 1, power-down 0.
// - watchdog expiry running: pin-wake 0, watchdog 0, power-down kept.
// - watchdog expiry waking from sleep: all three cause flags 0.
// - port-change wake: pin-wake 1, watchdog 1, power-down 0.
// - watchdog-clear instruction sets watchdog and power-down flags, pin-wake kept.
// - sleep instruction: watchdog flag 1, power-down 0, pin-wake kept.
// - three interrupt sources: tick overflow, port change, external pin fall.
// - only input pins, excluding the external-interrupt pin, raise port change.
// - port-change wake continues inline if interrupts off, else vectors 008H.
// - requests held in flag register, masked per source, gated globally.
// - enabled interrupt makes the core fetch from 008H.
// - tick and external flags set regardless of mask; port-change not.
// - flag register reads as flags AND mask.
// - return-from-isr re-enables global interrupts like the enable instruction.
// - trap instruction while enabled makes the core fetch from 001H.
// - any reset clears bits 0 to 2 of flag and mask registers.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module irq_and_reset_cause_flags (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire irq_cause_pkg::instr_s             instr,
    input  wire logic                              tick_overflow,
    input  wire logic                              ext_irq_pin,
    input  wire logic [irq_cause_pkg::PORT_W-1:0]  port_in,
    input  wire logic                              reset_pin_n,
    input  wire logic                              watchdog_expiry,
    output logic                                   core_reset,
    output logic                                   irq_request,
    output irq_cause_pkg::vector_s                 vector,
    output logic                                   wake_continue,
    output logic                                   asleep
);
    import irq_cause_pkg::*;

    state_s            s_r;
    state_s            s_nxt;
    logic              acc;
    logic              setup;
    logic              hit;
    logic [PORT_W-1:0] watch;
    logic              port_change;
    logic              ext_fall;
    logic              pin_rst;
    logic [2:0]        set_ev;
    logic [2:0]        pending;

    assign acc     = psel & penable;
    assign setup   = psel & ~penable;
    assign hit     = (paddr == OFS_FLAG) || (paddr == OFS_MASK) || (paddr == OFS_STATUS)
                     || (paddr == OFS_PORT) || (paddr == OFS_CONFIG);

    // event sources: pins left as outputs and the external-interrupt pin never count
    assign watch       = s_r.dir & ~{{(PORT_W-1){1'b0}}, s_r.ext_fn};
    assign port_change = |((port_in ^ s_r.ref_val) & watch);
    assign ext_fall    = s_r.ext_fn & s_r.ext_q & ~ext_irq_pin;
    // reset pin acts on the rising edge that ends its low pulse
    assign pin_rst     = reset_pin_n & ~s_r.rpin_q;

    // port change only latches while its mask bit is on, unlike the other two
    assign set_ev[BIT_TICK] = tick_overflow;
    assign set_ev[BIT_EXT]  = ext_fall;
    assign set_ev[BIT_PCHG] = port_change & s_r.irq_mask_reg[BIT_PCHG];

    assign pending = s_r.irq_flag_reg & s_r.irq_mask_reg;

    // bus answers in the access cycle, read data was captured at setup
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata  = s_r.rdata;

    // request held off in sleep; the wake path hands over to it one cycle later
    assign irq_request   = s_r.gie & (|pending) & (s_r.st == ST_RUN);
    assign core_reset    = s_r.core_rst;
    assign vector        = s_r.vec;
    assign wake_continue = s_r.wake_cont;
    assign asleep        = (s_r.st == ST_SLEEP);

    // next-state logic; later assignments take priority, resets last of all
    always_comb begin
        s_nxt           = s_r;
        s_nxt.core_rst  = 1'b0;
        s_nxt.vec.valid = 1'b0;
        s_nxt.wake_cont = 1'b0;
        s_nxt.ext_q     = ext_irq_pin;
        s_nxt.rpin_q    = reset_pin_n;

        // read data captured in setup so prdata comes straight from a flop
        if (setup && !pwrite) begin
            case (paddr)
                OFS_FLAG:   s_nxt.rdata = {29'h0, pending};
                OFS_MASK:   s_nxt.rdata = {29'h0, s_r.irq_mask_reg};
                OFS_STATUS: s_nxt.rdata = {24'h0, s_r.pin_wake, 2'b00, s_r.wdt_flag, s_r.pd_flag, 3'b000};
                OFS_PORT:   s_nxt.rdata = {24'h0, port_in};
                OFS_CONFIG: s_nxt.rdata = {23'h0, s_r.ext_fn, s_r.dir};
                default:    s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // register writes; reading the port refreshes the change reference
        if (acc && pwrite) begin
            case (paddr)
                OFS_FLAG:   s_nxt.irq_flag_reg = pwdata[2:0];
                OFS_MASK:   s_nxt.irq_mask_reg = pwdata[2:0];
                OFS_CONFIG: begin
                    s_nxt.dir    = pwdata[PORT_W-1:0];
                    s_nxt.ext_fn = pwdata[BIT_EXT_FN];
                end
                default: ;
            endcase
        end
        if (acc && !pwrite && paddr == OFS_PORT) begin
            s_nxt.ref_val = port_in;
        end

        // a hardware event beats a software clear in the same cycle
        s_nxt.irq_flag_reg = s_nxt.irq_flag_reg | set_ev;

        case (s_r.st)
            ST_RUN: begin
                if (instr.watchdog_clear_instr) begin
                    s_nxt.wdt_flag = 1'b1;
                    s_nxt.pd_flag  = 1'b1;
                end
                if (instr.global_irq_on_instr || instr.return_from_isr_instr) begin
                    s_nxt.gie = 1'b1;
                end
                if (instr.global_irq_off_instr) begin
                    s_nxt.gie = 1'b0;
                end
                // trap outranks a pending request; both drop the global enable
                if (instr.trap_instr && s_r.gie) begin
                    s_nxt.vec = '{valid: 1'b1, addr: VEC_TRAP};
                    s_nxt.gie = 1'b0;
                end else if (irq_request) begin
                    s_nxt.vec = '{valid: 1'b1, addr: VEC_IRQ};
                    s_nxt.gie = 1'b0;
                end
                if (instr.sleep_instr) begin
                    s_nxt.wdt_flag = 1'b1;
                    s_nxt.pd_flag  = 1'b0;
                    s_nxt.st       = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // only a masked-in port change wakes without a reset
                if (set_ev[BIT_PCHG]) begin
                    s_nxt.pin_wake  = 1'b1;
                    s_nxt.wdt_flag  = 1'b1;
                    s_nxt.pd_flag   = 1'b0;
                    s_nxt.st        = ST_RUN;
                    s_nxt.wake_cont = ~s_r.gie;
                end
            end
            default: s_nxt.st = ST_RUN;
        endcase

        // watchdog expiry resets the core; sleeping also clears power-down
        if (watchdog_expiry) begin
            s_nxt.pin_wake = 1'b0;
            s_nxt.wdt_flag = 1'b0;
            if (s_r.st == ST_SLEEP) begin
                s_nxt.pd_flag = 1'b0;
            end
        end
        // pin reset wins over a watchdog expiry in the same cycle only in sleep; running, the watchdog flag still clears
        if (pin_rst) begin
            s_nxt.pin_wake = 1'b0;
            if (s_r.st == ST_SLEEP) begin
                s_nxt.wdt_flag = 1'b1;
                s_nxt.pd_flag  = 1'b0;
            end else begin
                s_nxt.wdt_flag = watchdog_expiry ? 1'b0 : s_r.wdt_flag;
            end
        end
        if (pin_rst || watchdog_expiry) begin
            s_nxt.irq_flag_reg = FLAG_RST;
            s_nxt.irq_mask_reg = MASK_RST;
            s_nxt.gie          = 1'b0;
            s_nxt.st           = ST_RUN;
            s_nxt.dir          = DIR_RST;
            s_nxt.ext_fn       = 1'b0;
            s_nxt.vec.valid    = 1'b0;
            s_nxt.wake_cont    = 1'b0;
            s_nxt.core_rst     = 1'b1;
        end
    end

    // power-on: async clear to the cause pattern of a fresh start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // irq_and_reset_cause_flags

`default_nettype wire

/* test/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model import irq_cause_pkg::*; (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   core_reset,
    input wire irq_cause_pkg::vector_s vector,
    input wire logic                   wake_continue,
    output logic [9:0]                 pc
);
    // fetch address: restart, vector jump or step past the sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pc <= 10'h000;
        else if (core_reset) pc <= 10'h000;
        else if (vector.valid) pc <= vector.addr;
        else if (wake_continue) pc <= pc + 10'h001;
    end
endmodule // core_model
`default_nettype wire

/* test/irq_cause_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_cause_chk import irq_cause_pkg::*; (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [7:0]            paddr,
    input wire logic                  pslverr,
    input wire irq_cause_pkg::instr_s instr,
    input wire logic                  reset_pin_n,
    input wire logic                  watchdog_expiry,
    input wire logic                  core_reset,
    input wire logic                  irq_request,
    input wire irq_cause_pkg::vector_s vector,
    input wire logic                  wake_continue,
    input wire logic                  asleep
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a pin reset needs the full low-then-high pulse
    sequence pin_pulse_s;
        !reset_pin_n ##1 reset_pin_n;
    endsequence
    // a vector is issued once, with the request withdrawn
    sequence vec_done_s;
        !irq_request ##1 !vector.valid;
    endsequence
    pin_rst_a: assert property (pin_pulse_s |=> core_reset)
        else $error("pin pulse gave no core reset");
    wdt_rst_a: assert property (watchdog_expiry |=> core_reset)
        else $error("watchdog expiry gave no core reset");
    // a reset event in the same cycle cancels the vector, so it is left out here
    irq_vec_a: assert property (irq_request && !instr.trap_instr && !watchdog_expiry && !$rose(reset_pin_n)
        |=> vector.valid && vector.addr == VEC_IRQ)
        else $error("pending request not vectored to irq address");
    trap_cause_a: assert property (vector.valid && vector.addr == VEC_TRAP |-> $past(instr.trap_instr))
        else $error("trap vector without trap instruction");
    vec_once_a: assert property (vector.valid |-> vec_done_s)
        else $error("vector repeated or request still up");
    sleep_enter_a: assert property (instr.sleep_instr && !asleep && !watchdog_expiry && reset_pin_n |=> asleep)
        else $error("sleep instruction did not stop the core");
    sleep_quiet_a: assert property (asleep |=> !vector.valid)
        else $error("vector issued straight out of sleep");
    wake_cont_a: assert property (wake_continue |-> !asleep && !irq_request)
        else $error("inline wake with interrupt pending or still asleep");
    unmapped_err_a: assert property (psel && penable && paddr > OFS_CONFIG |-> pslverr)
        else $error("unmapped access not refused");
endmodule // irq_cause_chk
bind irq_and_reset_cause_flags irq_cause_chk chk (.*);
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import irq_cause_pkg::*;
    localparam instr_s I_WDC = 6'h20, I_SLP = 6'h10, I_ON = 6'h08, I_OFF = 6'h04, I_RETURN_FROM_ISR_INSTR = 6'h02, I_TRAP = 6'h01;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic tick_overflow = 1'b0, ext_irq_pin = 1'b1, reset_pin_n = 1'b1, watchdog_expiry = 1'b0;
    logic [7:0] paddr = 8'h00, port_in = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, core_reset, irq_request, wake_continue, asleep;
    logic [9:0] pc;
    instr_s instr = '0;
    vector_s vector;
    int miscompares = 0, samples_checked = 0;
    always #2 pclk = ~pclk;
    irq_and_reset_cause_flags dut (.*);
    core_model core (.*);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; an idle edge after keeps psel single-driven
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask
    function automatic logic [31:0] st(input logic w, input logic t, input logic p);
        st = 32'h0;
        st[BIT_PIN_WAKE] = w;
        st[BIT_WDT] = t;
        st[BIT_PD] = p;
    endfunction
    task automatic ins(input instr_s v);
        instr <= v;
        @(posedge pclk);
        instr <= '0;
        step(3);
    endtask
    // one-cycle reset pin pulse or watchdog expiry
    task automatic hit(input logic pin);
        if (pin) reset_pin_n <= 1'b0;
        else watchdog_expiry <= 1'b1;
        step(1);
        reset_pin_n <= 1'b1;
        watchdog_expiry <= 1'b0;
        step(3);
    endtask
    task automatic t_irq;
        rd(OFS_STATUS, st(0, 1, 1), "status por");
        rd(OFS_FLAG, 32'h0, "flag rst");
        rd(OFS_MASK, 32'h0, "mask rst");
        tick_overflow <= 1'b1;
        step(1);
        tick_overflow <= 1'b0;
        apb(1'b1, OFS_MASK, 32'h1);
        rd(OFS_FLAG, 32'h1, "flag tick");
        apb(1'b1, OFS_CONFIG, 32'h1FF);
        ext_irq_pin <= 1'b0;
        step(2);
        ext_irq_pin <= 1'b1;
        rd(OFS_FLAG, 32'h1, "flag masked");
        apb(1'b1, OFS_MASK, 32'h5);
        rd(OFS_FLAG, 32'h5, "flag ext");
        ins(I_ON);
        chk("irq fetch", 32'h8, {22'h0, pc});
        apb(1'b1, OFS_FLAG, 32'h0);
        ins(I_RETURN_FROM_ISR_INSTR);
        chk("no reentry", 32'h8, {22'h0, pc});
        ins(I_TRAP);
        chk("trap fetch", 32'h1, {22'h0, pc});
        rd(8'h20, 32'h0, "unmapped");
        $display("test irq done");
    endtask
    task automatic t_port;
        apb(1'b1, OFS_CONFIG, 32'h0DF);
        rd(OFS_PORT, 32'h0, "port ref");
        apb(1'b1, OFS_MASK, 32'h2);
        port_in <= 8'h20;
        step(2);
        rd(OFS_FLAG, 32'h0, "output pin");
        ins(I_OFF);
        ins(I_SLP);
        rd(OFS_STATUS, st(0, 1, 0), "status sleep");
        chk("asleep", 32'h1, {31'h0, asleep});
        port_in <= 8'h24;
        step(4);
        chk("inline wake", 32'h2, {22'h0, pc});
        rd(OFS_STATUS, st(1, 1, 0), "status wake");
        rd(OFS_PORT, 32'h24, "port reload");
        apb(1'b1, OFS_FLAG, 32'h0);
        ins(I_ON);
        ins(I_SLP);
        port_in <= 8'h2C;
        step(4);
        chk("irq wake", 32'h8, {22'h0, pc});
        $display("test port done");
    endtask
    task automatic t_cause;
        ins(I_WDC);
        rd(OFS_STATUS, st(1, 1, 1), "wdt clear");
        hit(1'b1);
        chk("pin reset pc", 32'h0, {22'h0, pc});
        rd(OFS_STATUS, st(0, 1, 1), "pin run");
        hit(1'b0);
        rd(OFS_STATUS, st(0, 0, 1), "wdt run");
        ins(I_SLP);
        hit(1'b0);
        rd(OFS_STATUS, st(0, 0, 0), "wdt sleep");
        ins(I_SLP);
        hit(1'b1);
        rd(OFS_STATUS, st(0, 1, 0), "pin sleep");
        chk("awake", 32'h0, {31'h0, asleep});
        $display("test cause done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence: reset for six cycles, then the scenarios
    initial begin
        step(6);
        presetn <= 1'b1;
        step(1);
        t_irq;
        t_port;
        t_cause;
        conclude;
    end
    // hang guard, far beyond the roughly 150 cycles the tests need
    initial begin
        step(20000);
        miscompares++;
        conclude;
    end
endmodule // tb_top
`default_nettype wire
